// >>> pmae_pkg.sv
// Constants, types and ECC helpers for the parameter memory access block
package pmae_pkg;
  // Protected parameter memory geometry
  localparam int MEM_BYTES  = 1536;
  localparam int TRAP_BYTES = 4;
  localparam int WR_MAX_DEF = 256;

  // Command codes and reply marker
  localparam logic [7:0] CODE_READ   = 8'h09;
  localparam logic [7:0] CODE_WRITE  = 8'h0a;
  localparam logic [7:0] CODE_GATHER = 8'h0b;
  localparam logic [7:0] ERR_BYTE    = 8'hff;

  // Argument layout
  localparam logic [2:0]  ARG_SHORT     = 3'h3;
  localparam logic [2:0]  ARG_LONG      = 3'h4;
  localparam logic [16:0] SHORT_ZERO    = 17'h00100;
  localparam logic [2:0]  HDR_RW_BYTES  = 3'h2;
  localparam logic [2:0]  HDR_GA_BYTES  = 3'h4;

  // Timing at 200 MHz
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int CYC_PER_MS      = 1000000000 / CLK_PERIOD_PS;
  localparam int NV_ON_DELAY_US  = 1000;
  localparam int NV_ON_CYCLES    = (NV_ON_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCRUB_PERIOD_MS = 2000;
  localparam int SCRUB_GAP_CYCLES = (SCRUB_PERIOD_MS * CYC_PER_MS) / MEM_BYTES;

  // Boot copy of the factory region into program RAM
  localparam int          BOOT_COPY_BYTES = 128 * 1024;
  localparam logic [16:0] PRAM_TRAP_BASE  = 17'h1fffc;

  // Processor memory map
  localparam logic [31:0] PRAM_END  = 32'h0001ffff;
  localparam logic [31:0] PRAM_TRAP = 32'h0001fffc;
  localparam logic [31:0] DRAM_BASE = 32'h10000000;
  localparam logic [31:0] DRAM_TRAP = 32'h10007ffc;
  localparam logic [31:0] DRAM_END  = 32'h10007fff;
  localparam logic [31:0] BNV_BASE  = 32'h20000000;
  localparam logic [31:0] BNV_END   = 32'h2003ffff;
  localparam logic [31:0] UNV_BASE  = 32'h20050000;
  localparam logic [31:0] UNV_END   = 32'h2007ffff;
  localparam logic [31:0] HWR_BASE  = 32'h40000000;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_PRAM = 3'b001,
    REG_DRAM = 3'b010,
    REG_BNV  = 3'b011,
    REG_UNV  = 3'b100,
    REG_HWR  = 3'b101
  } pmae_region_e;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_ARG   = 4'b0001,
    S_WSTG  = 4'b0010,
    S_CHK   = 4'b0011,
    S_HDR   = 4'b0100,
    S_RD    = 4'b0101,
    S_WR    = 4'b0110,
    S_ERR   = 4'b0111,
    S_DRAIN = 4'b1000
  } pmae_state_e;

  typedef enum logic [1:0] {
    B_PWR  = 2'b00,
    B_COPY = 2'b01,
    B_DONE = 2'b10
  } pmae_boot_e;

  // Weight-3 columns: one flipped data bit gives odd weight, two give even
  localparam logic [4:0] ECC_COL [8] = '{5'h07, 5'h0b, 5'h0d, 5'h0e, 5'h13, 5'h15, 5'h16, 5'h19};

  function automatic logic [4:0] ecc_gen(input logic [7:0] d);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 8; i++) begin
      if (d[i]) begin
        s = s ^ ECC_COL[i];
      end
    end
    return s;
  endfunction
endpackage

// >>> pmae_core.sv
// Parameter memory command interpreter with ECC, scrub, boot copy and map decode
//
// Contract
// - read code 0x09, short count zero means 256
// - read also accepts 2-byte count long form
// - read reply echoes address then data
// - read returns one consistent memory snapshot
// - write code 0x0a, stored as one update
// - write reply echoes address then written data
// - gather code 0x0b, 4-byte address/count entries
// - gather entry reply: address, count, data
// - all gather ranges read atomically
// - sparse 32-bit map, registers from 0x40000000
// - program RAM with trap word at top
// - data RAM with trap word at top
// - factory NV write-protected, user NV writable
// - every reset copies 128 kB into program RAM
// - data RAM cleared on power-up only
// - each byte stored with 5-bit syndrome
// - single errors fixed and repaired, multi detected
// - hardware scrub revisits every location periodically
// - NV powered off unused, 1 ms wait
// - trap word stored syndrome always zero
// - one-bit trap byte gives corrected error
// - two-bit trap byte gives counted multi error
// - protected parameter memory spans 1536 bytes
// - error counters: single low, multi high
`timescale 1ns/10ps
module pmae_core #(
  parameter int NV_ON_CYC = pmae_pkg::NV_ON_CYCLES,
  parameter int SCRUB_GAP = pmae_pkg::SCRUB_GAP_CYCLES,
  parameter int WR_MAX    = pmae_pkg::WR_MAX_DEF
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 pwr_on_rst,
  input  wire logic                 cmd_valid,
  input  wire logic [7:0]           cmd_data,
  input  wire logic                 cmd_last,
  output logic                      cmd_ready,
  output logic                      rsp_valid,
  output logic [7:0]                rsp_data,
  output logic                      rsp_last,
  input  wire logic                 rsp_ready,
  input  wire logic [31:0]          map_addr,
  input  wire logic                 map_wr,
  output pmae_pkg::pmae_region_e    map_region,
  output logic                      map_trap,
  output logic                      map_wr_ok,
  output logic [31:0]               err_count,
  output logic                      nv_pwr_on,
  output logic                      nv_rd_req,
  output logic [16:0]               nv_rd_addr,
  input  wire logic [7:0]           nv_rd_data,
  output logic                      pram_we,
  output logic [16:0]               pram_addr,
  output logic [7:0]                pram_wdata,
  output logic [4:0]                pram_wsyn,
  output logic                      boot_done
);
  import pmae_pkg::*;

  pmae_state_e  state_q;
  pmae_boot_e   boot_q;
  pmae_region_e map_region_q;
  logic [7:0]   code_q;
  logic [31:0]  arg_q;
  logic [2:0]   argn_q;
  logic [8:0]   wn_q;
  logic [7:0]   idx_q;
  logic [10:0]  ptr_q;
  logic [16:0]  left_q;
  logic [31:0]  hdr_q;
  logic [2:0]   hdrn_q;
  logic         hdr_last_q;
  logic         final_q;
  logic         cmd_ready_q;
  logic [7:0]   stage [WR_MAX];
  logic [7:0]   mem_d [MEM_BYTES];
  logic [4:0]   mem_s [MEM_BYTES];
  logic         start_q;
  logic         clr_busy_q;
  logic [10:0]  clr_ptr_q;
  logic [31:0]  scr_cnt_q;
  logic [10:0]  scr_ptr_q;
  logic [31:0]  err_count_q;
  logic [1:0]   buf_cnt_q;
  logic [7:0]   rsp_data_q;
  logic         rsp_last_q;
  logic         rsp_valid_q;
  logic [7:0]   buf1_data_q;
  logic         buf1_last_q;
  logic         map_trap_q;
  logic         map_wr_ok_q;
  logic [31:0]  boot_cnt_q;
  logic         nv_pwr_on_q;
  logic         nv_rd_req_q;
  logic [16:0]  nv_rd_addr_q;
  logic         pram_we_q;
  logic [16:0]  pram_addr_q;
  logic [7:0]   pram_wdata_q;
  logic [4:0]   pram_wsyn_q;
  logic         boot_done_q;
  logic         cp_req_q;
  logic [16:0]  cp_addr_q;

  logic         take;
  logic         in_rdy;
  logic         push;
  logic         pop;
  logic [7:0]   push_data;
  logic         push_last;
  logic [16:0]  chk_len;
  logic         chk_ok;
  logic         scr_go;
  logic         scr_tick;
  logic [10:0]  rd_idx;
  logic [7:0]   rd_raw;
  logic [4:0]   rd_syn;
  logic [7:0]   rd_fix;
  logic         rd_hit;
  logic         rd_single;
  logic         rd_multi;
  logic         rd_use;
  logic         mem_we;
  logic [10:0]  mem_wa;
  logic [7:0]   mem_wd;
  logic [4:0]   mem_ws;

  assign take      = cmd_valid & cmd_ready_q;
  assign in_rdy    = (buf_cnt_q != 2'd2);
  assign pop       = rsp_valid_q & rsp_ready;
  assign scr_go    = (state_q == S_IDLE) & ~clr_busy_q;
  assign scr_tick  = scr_go & (scr_cnt_q == 32'(SCRUB_GAP - 1));

  assign cmd_ready  = cmd_ready_q;
  assign rsp_valid  = rsp_valid_q;
  assign rsp_data   = rsp_data_q;
  assign rsp_last   = rsp_last_q;
  assign map_region = map_region_q;
  assign map_trap   = map_trap_q;
  assign map_wr_ok  = map_wr_ok_q;
  assign err_count  = err_count_q;
  assign nv_pwr_on  = nv_pwr_on_q;
  assign nv_rd_req  = nv_rd_req_q;
  assign nv_rd_addr = nv_rd_addr_q;
  assign pram_we    = pram_we_q;
  assign pram_addr  = pram_addr_q;
  assign pram_wdata = pram_wdata_q;
  assign pram_wsyn  = pram_wsyn_q;
  assign boot_done  = boot_done_q;

  // Range length by command; the short form is known by its three-byte argument
  always_comb begin
    if (code_q == CODE_WRITE) begin
      chk_len = {8'h00, wn_q};
    end else if (code_q == CODE_READ && argn_q == ARG_SHORT) begin
      chk_len = (arg_q[23:16] == 8'h00) ? SHORT_ZERO : {9'h000, arg_q[23:16]};
    end else begin
      chk_len = {1'b0, arg_q[31:16]};
    end
  end
  assign chk_ok = (({1'b0, arg_q[15:0]} + chk_len) <= 17'(MEM_BYTES));

  // Read port is shared; scrub borrows it only while the interpreter idles
  assign rd_idx = (state_q == S_IDLE) ? scr_ptr_q : ptr_q;
  assign rd_raw = mem_d[rd_idx];
  assign rd_syn = ecc_gen(rd_raw) ^ mem_s[rd_idx];
  always_comb begin
    rd_fix = rd_raw;
    rd_hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (rd_syn == ECC_COL[i]) begin
        rd_fix[i] = ~rd_raw[i];
        rd_hit    = 1'b1;
      end
    end
  end
  // A lone check-bit flip leaves the data intact but still gets repaired
  assign rd_single = rd_hit | ((rd_syn != 5'h00) & ((rd_syn & (rd_syn - 5'h01)) == 5'h00));
  assign rd_multi  = (rd_syn != 5'h00) & ~rd_single;
  assign rd_use    = ((state_q == S_RD) & in_rdy) | scr_tick;

  // Single write port: clear, then commit, then repair
  always_comb begin
    mem_we = 1'b0;
    mem_wa = ptr_q;
    mem_wd = stage[idx_q];
    if (clr_busy_q) begin
      mem_we = 1'b1;
      mem_wa = clr_ptr_q;
      mem_wd = 8'h00;
    end else if (state_q == S_WR && in_rdy) begin
      mem_we = 1'b1;
    end else if (rd_use && rd_single) begin
      mem_we = 1'b1;
      mem_wa = rd_idx;
      mem_wd = rd_fix;
    end
  end
  assign mem_ws = ecc_gen(mem_wd);

  // Storage without reset so contents survive warm resets
  for (genvar g = 0; g < MEM_BYTES; g++) begin : g_mem
    always_ff @(posedge sys_clk) begin
      if (mem_we && mem_wa == 11'(g)) begin
        mem_d[g] <= mem_wd;
        mem_s[g] <= (g >= MEM_BYTES - TRAP_BYTES) ? 5'h00 : mem_ws;
      end
    end
  end

  // Staging keeps a write invisible until every byte is in and checked
  always_ff @(posedge sys_clk) begin
    if (state_q == S_WSTG && take && wn_q < 9'(WR_MAX)) begin
      stage[wn_q[7:0]] <= cmd_data;
    end
  end

  // Byte offered to the reply buffer
  always_comb begin
    push      = in_rdy;
    push_data = ERR_BYTE;
    push_last = 1'b1;
    case (state_q)
      S_HDR: begin
        push_data = hdr_q[7:0];
        push_last = (hdrn_q == 3'h1) & hdr_last_q;
      end
      S_RD: begin
        push_data = rd_fix;
        push_last = (left_q == 17'h00001) & final_q;
      end
      S_WR: begin
        push_data = stage[idx_q];
        push_last = (left_q == 17'h00001) & final_q;
      end
      S_ERR: push = in_rdy;
      default: push = 1'b0;
    endcase
  end

  // Command sequencer; memory is owned here, so each command is atomic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= S_IDLE;
      cmd_ready_q <= 1'b0;
      code_q      <= 8'h00;
      arg_q       <= 32'h00000000;
      argn_q      <= 3'h0;
      wn_q        <= 9'h000;
      idx_q       <= 8'h00;
      ptr_q       <= 11'h000;
      left_q      <= 17'h00000;
      hdr_q       <= 32'h00000000;
      hdrn_q      <= 3'h0;
      hdr_last_q  <= 1'b0;
      final_q     <= 1'b0;
    end else begin
      cmd_ready_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          cmd_ready_q <= ~clr_busy_q & ~start_q;
          if (take) begin
            code_q  <= cmd_data;
            argn_q  <= 3'h0;
            wn_q    <= 9'h000;
            final_q <= 1'b1;
            cmd_ready_q <= ~cmd_last;
            if (cmd_last) begin
              state_q <= S_ERR;
            end else if (cmd_data == CODE_READ || cmd_data == CODE_WRITE || cmd_data == CODE_GATHER) begin
              state_q <= S_ARG;
            end else begin
              state_q <= S_DRAIN;
            end
          end
        end
        S_ARG: begin
          cmd_ready_q <= 1'b1;
          if (take) begin
            arg_q[{argn_q[1:0], 3'b000} +: 8] <= cmd_data;
            argn_q <= argn_q + 3'h1;
            if (code_q == CODE_WRITE && argn_q == 3'h1) begin
              cmd_ready_q <= ~cmd_last;
              state_q     <= cmd_last ? S_CHK : S_WSTG;
            end else if (cmd_last) begin
              cmd_ready_q <= 1'b0;
              final_q     <= 1'b1;
              if ((code_q == CODE_READ && (argn_q == 3'h2 || argn_q == 3'h3)) ||
                  (code_q == CODE_GATHER && argn_q == 3'h3)) begin
                state_q <= S_CHK;
              end else begin
                state_q <= S_ERR;
              end
            end else if (argn_q == 3'h3) begin
              if (code_q == CODE_GATHER) begin
                cmd_ready_q <= 1'b0;
                final_q     <= 1'b0;
                state_q     <= S_CHK;
              end else begin
                state_q <= S_DRAIN;
              end
            end
          end
        end
        S_WSTG: begin
          cmd_ready_q <= 1'b1;
          if (take) begin
            if (wn_q == 9'(WR_MAX)) begin
              cmd_ready_q <= ~cmd_last;
              state_q     <= cmd_last ? S_ERR : S_DRAIN;
            end else begin
              wn_q <= wn_q + 9'h001;
              if (cmd_last) begin
                cmd_ready_q <= 1'b0;
                state_q     <= S_CHK;
              end
            end
          end
        end
        S_DRAIN: begin
          cmd_ready_q <= 1'b1;
          if (take && cmd_last) begin
            cmd_ready_q <= 1'b0;
            state_q     <= S_ERR;
          end
        end
        S_CHK: begin
          if (!chk_ok && code_q != CODE_GATHER) begin
            state_q <= S_ERR;
          end else begin
            // A gather range out of bounds answers with a zero count
            hdr_q      <= {(chk_ok ? chk_len[15:0] : 16'h0000), arg_q[15:0]};
            hdrn_q     <= (code_q == CODE_GATHER) ? HDR_GA_BYTES : HDR_RW_BYTES;
            hdr_last_q <= final_q & (~chk_ok | (chk_len == 17'h00000));
            left_q     <= chk_ok ? chk_len : 17'h00000;
            ptr_q      <= arg_q[10:0];
            idx_q      <= 8'h00;
            state_q    <= S_HDR;
          end
        end
        S_HDR: begin
          if (in_rdy) begin
            hdr_q  <= {8'h00, hdr_q[31:8]};
            hdrn_q <= hdrn_q - 3'h1;
            if (hdrn_q == 3'h1) begin
              if (left_q != 17'h00000) begin
                state_q <= (code_q == CODE_WRITE) ? S_WR : S_RD;
              end else begin
                state_q     <= final_q ? S_IDLE : S_ARG;
                argn_q      <= 3'h0;
                cmd_ready_q <= 1'b1;
              end
            end
          end
        end
        S_RD, S_WR: begin
          if (in_rdy) begin
            ptr_q  <= ptr_q + 11'h001;
            idx_q  <= idx_q + 8'h01;
            left_q <= left_q - 17'h00001;
            if (left_q == 17'h00001) begin
              state_q     <= final_q ? S_IDLE : S_ARG;
              argn_q      <= 3'h0;
              cmd_ready_q <= 1'b1;
            end
          end
        end
        S_ERR: begin
          if (in_rdy) begin
            state_q     <= S_IDLE;
            cmd_ready_q <= 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Two-entry reply buffer; a stalled receiver holds the sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_cnt_q   <= 2'd0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      rsp_last_q  <= 1'b0;
      buf1_data_q <= 8'h00;
      buf1_last_q <= 1'b0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (buf_cnt_q == 2'd0) begin
            rsp_data_q <= push_data;
            rsp_last_q <= push_last;
          end else begin
            buf1_data_q <= push_data;
            buf1_last_q <= push_last;
          end
          buf_cnt_q   <= buf_cnt_q + 2'd1;
          rsp_valid_q <= 1'b1;
        end
        2'b01: begin
          rsp_data_q  <= buf1_data_q;
          rsp_last_q  <= buf1_last_q;
          buf_cnt_q   <= buf_cnt_q - 2'd1;
          rsp_valid_q <= (buf_cnt_q == 2'd2);
        end
        2'b11: begin
          rsp_data_q <= push_data;
          rsp_last_q <= push_last;
        end
        default: buf_cnt_q <= buf_cnt_q;
      endcase
    end
  end

  // Power-up clear; the cause is sampled on the first edge after release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q    <= 1'b1;
      clr_busy_q <= 1'b0;
      clr_ptr_q  <= 11'h000;
    end else if (start_q) begin
      start_q    <= 1'b0;
      clr_busy_q <= pwr_on_rst;
      clr_ptr_q  <= 11'h000;
    end else if (clr_busy_q) begin
      clr_ptr_q <= clr_ptr_q + 11'h001;
      if (clr_ptr_q == 11'(MEM_BYTES - 1)) begin
        clr_busy_q <= 1'b0;
      end
    end
  end

  // Scrub one byte per gap; waits for idle so commands stay atomic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scr_cnt_q <= 32'h00000000;
      scr_ptr_q <= 11'h000;
    end else if (scr_cnt_q != 32'(SCRUB_GAP - 1)) begin
      scr_cnt_q <= scr_cnt_q + 32'h00000001;
    end else if (scr_go) begin
      scr_cnt_q <= 32'h00000000;
      scr_ptr_q <= (scr_ptr_q == 11'(MEM_BYTES - 1)) ? 11'h000 : scr_ptr_q + 11'h001;
    end
  end

  // Saturating error counters: single low half, multi high half
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_count_q <= 32'h00000000;
    end else if (rd_use) begin
      if (rd_single && err_count_q[15:0] != 16'hffff) begin
        err_count_q[15:0] <= err_count_q[15:0] + 16'h0001;
      end
      if (rd_multi && err_count_q[31:16] != 16'hffff) begin
        err_count_q[31:16] <= err_count_q[31:16] + 16'h0001;
      end
    end
  end

  // Registered processor address decode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_region_q <= REG_NONE;
      map_trap_q   <= 1'b0;
      map_wr_ok_q  <= 1'b0;
    end else begin
      map_trap_q  <= (map_addr >= PRAM_TRAP && map_addr <= PRAM_END) ||
                     (map_addr >= DRAM_TRAP && map_addr <= DRAM_END);
      map_wr_ok_q <= map_wr;
      if (map_addr <= PRAM_END) begin
        map_region_q <= REG_PRAM;
      end else if (map_addr >= DRAM_BASE && map_addr <= DRAM_END) begin
        map_region_q <= REG_DRAM;
      end else if (map_addr >= BNV_BASE && map_addr <= BNV_END) begin
        map_region_q <= REG_BNV;
        map_wr_ok_q  <= 1'b0;
      end else if (map_addr >= UNV_BASE && map_addr <= UNV_END) begin
        map_region_q <= REG_UNV;
      end else if (map_addr >= HWR_BASE) begin
        map_region_q <= REG_HWR;
      end else begin
        map_region_q <= REG_NONE;
        map_wr_ok_q  <= 1'b0;
      end
    end
  end

  // Boot copy: power NV on, settle, stream into program RAM, power off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q       <= B_PWR;
      boot_cnt_q   <= 32'h00000000;
      nv_pwr_on_q  <= 1'b0;
      nv_rd_req_q  <= 1'b0;
      nv_rd_addr_q <= 17'h00000;
      boot_done_q  <= 1'b0;
    end else begin
      case (boot_q)
        B_PWR: begin
          nv_pwr_on_q <= 1'b1;
          boot_cnt_q  <= boot_cnt_q + 32'h00000001;
          if (boot_cnt_q == 32'(NV_ON_CYC - 1)) begin
            boot_q <= B_COPY;
          end
        end
        B_COPY: begin
          nv_rd_req_q <= 1'b1;
          if (nv_rd_req_q && nv_rd_addr_q == 17'(BOOT_COPY_BYTES - 1)) begin
            nv_rd_req_q <= 1'b0;
            boot_q      <= B_DONE;
          end else if (nv_rd_req_q) begin
            nv_rd_addr_q <= nv_rd_addr_q + 17'h00001;
          end
        end
        B_DONE: begin
          nv_pwr_on_q <= 1'b0;
          boot_done_q <= 1'b1;
        end
        default: boot_q <= B_PWR;
      endcase
    end
  end

  // Program RAM write; address waits a cycle for its NV byte to arrive
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_req_q     <= 1'b0;
      cp_addr_q    <= 17'h00000;
      pram_we_q    <= 1'b0;
      pram_addr_q  <= 17'h00000;
      pram_wdata_q <= 8'h00;
      pram_wsyn_q  <= 5'h00;
    end else begin
      cp_req_q     <= nv_rd_req_q;
      cp_addr_q    <= nv_rd_addr_q;
      pram_we_q    <= cp_req_q;
      pram_addr_q  <= cp_addr_q;
      pram_wdata_q <= nv_rd_data;
      pram_wsyn_q  <= (cp_addr_q >= PRAM_TRAP_BASE) ? 5'h00 : ecc_gen(nv_rd_data);
    end
  end
endmodule

// >>> pmae_nv_model.sv
// Non-volatile memory model serving the boot copy
`timescale 1ns/10ps
module pmae_nv_model (
  input  wire logic        sys_clk,
  input  wire logic        nv_rd_req,
  input  wire logic [16:0] nv_rd_addr,
  output logic      [7:0]  nv_rd_data = 8'h00
);
  // Unrequested cycles toggle, so a stale byte never looks valid
  always @(posedge sys_clk) begin
    nv_rd_data <= nv_rd_req ? nv_rd_addr[7:0] : ~nv_rd_data;
  end
endmodule

// >>> pmae_checker.sv
// Assertions on the reply stream, map decode and boot ports
`timescale 1ns/10ps
module pmae_checker #(
  parameter int NV_ON_CYC = 8
) (
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic                   rsp_valid,
  input wire logic [7:0]             rsp_data,
  input wire logic                   rsp_ready,
  input wire logic [31:0]            map_addr,
  input wire logic                   map_wr,
  input wire pmae_pkg::pmae_region_e map_region,
  input wire logic                   map_trap,
  input wire logic                   map_wr_ok,
  input wire logic                   nv_pwr_on,
  input wire logic                   nv_rd_req,
  input wire logic                   pram_we,
  input wire logic [16:0]            pram_addr,
  input wire logic [7:0]             pram_wdata
);
  import pmae_pkg::*;
  logic up_q;
  int   on_q;
  // Decode settles one edge after reset; on_q counts powered cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 1'h0;
      on_q <= 0;
    end else begin
      up_q <= 1'h1;
      on_q <= nv_pwr_on ? on_q + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("stalled byte changed");
  a_region_hwr: assert property (up_q && $past(map_addr) >= HWR_BASE |-> map_region == REG_HWR)
    else $error("register area wrong");
  a_region_pram: assert property (up_q && $past(map_addr) <= PRAM_END |-> map_region == REG_PRAM)
    else $error("program area wrong");
  a_trap_flag: assert property (up_q |->
    map_trap == ($past(map_addr) inside {[PRAM_TRAP:PRAM_END], [DRAM_TRAP:DRAM_END]}))
    else $error("trap flag wrong");
  a_factory_ro: assert property (map_region == REG_BNV |-> !map_wr_ok)
    else $error("factory area writable");
  a_wr_cause: assert property (map_wr_ok |-> $past(map_wr) && map_region != REG_NONE)
    else $error("write enable without cause");
  a_nv_settle: assert property (nv_rd_req |-> nv_pwr_on && on_q >= NV_ON_CYC - 1)
    else $error("read before settle time");
  a_copy_write: assert property (nv_rd_req |=> ##1 pram_we)
    else $error("copied byte not written");
  a_copy_data: assert property (pram_we |-> pram_wdata == pram_addr[7:0])
    else $error("copied byte wrong");
endmodule

// >>> pmae_core_tb_top.sv
// Self-checking bench for the parameter memory core
`timescale 1ns/10ps
module pmae_core_tb_top;
  import pmae_pkg::*;
  typedef logic [7:0] pmae_q_t[$];
  logic         sys_clk = 1'h0, rst_n = 1'h0, pwr_on_rst = 1'h1, cmd_valid = 1'h0, cmd_last = 1'h0;
  logic         rsp_ready = 1'h0, map_wr = 1'h1, cmd_ready, rsp_valid, rsp_last, map_trap, map_wr_ok, nv_rd_req;
  logic [7:0]   cmd_data = 8'h00, rsp_data, nv_rd_data;
  logic [31:0]  map_addr = 32'h0, err_count;
  logic [16:0]  nv_rd_addr;
  pmae_region_e map_region;
  int           n_errors = 0, num_checks = 0, cyc = 0;
  pmae_core #(.NV_ON_CYC(8), .SCRUB_GAP(4)) pmae_core_i (.sys_clk, .rst_n, .pwr_on_rst, .cmd_valid, .cmd_data,
    .cmd_last, .cmd_ready, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready, .map_addr, .map_wr, .map_region,
    .map_trap, .map_wr_ok, .err_count, .nv_pwr_on(), .nv_rd_req, .nv_rd_addr, .nv_rd_data, .pram_we(),
    .pram_addr(), .pram_wdata(), .pram_wsyn(), .boot_done());
  pmae_nv_model pmae_nv_model_i (.sys_clk, .nv_rd_req, .nv_rd_addr, .nv_rd_data);
  // Clock; receiver stalls every third cycle; the ceiling cuts a hang
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rsp_ready <= cyc % 3 != 0;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Sends a frame while collecting the reply, then compares it
  task automatic xf(pmae_q_t c, pmae_q_t e);
    pmae_q_t g;
    int n = 0;
    fork
      begin
        foreach (c[i]) begin
          cmd_valid <= 1'h1;
          cmd_data <= c[i];
          cmd_last <= i == c.size() - 1;
          do @(posedge sys_clk); while (!cmd_ready);
        end
        cmd_valid <= 1'h0;
      end
      do begin
        @(posedge sys_clk);
        n++;
        if (rsp_valid && rsp_ready) g.push_back(rsp_data);
      end while (!(rsp_valid && rsp_ready && rsp_last) && n < 5000);
    join
    chk("len", g.size(), e.size());
    foreach (e[i]) chk("rsp", g[i], e[i]);
  endtask
  task automatic t_rw();
    xf('{CODE_WRITE, 8'h10, 8'h00, 8'ha1, 8'hb2, 8'hc3}, '{8'h10, 8'h00, 8'ha1, 8'hb2, 8'hc3});
    xf('{CODE_READ, 8'h0f, 8'h00, 8'h03}, '{8'h0f, 8'h00, 8'h00, 8'ha1, 8'hb2});
    xf('{CODE_READ, 8'h11, 8'h00, 8'h02, 8'h00}, '{8'h11, 8'h00, 8'hb2, 8'hc3});
    $display("t_rw end");
  endtask
  // Zero count reads 256 bytes of cleared memory, except the three bytes that t_rw wrote at 0x10
  task automatic t_full();
    pmae_q_t e = '{8'h00, 8'h00};
    for (int i = 0; i < 256; i++) e.push_back(i inside {[16:18]} ? 8'(8'h91 + 8'h11 * i) : 8'h00);
    xf('{CODE_READ, 8'h00, 8'h00, 8'h00}, e);
    $display("t_full end");
  endtask
  task automatic t_rng();
    xf('{CODE_GATHER, 8'h11, 8'h00, 8'h01, 8'h00, 8'hff, 8'h05, 8'h02, 8'h00},
       '{8'h11, 8'h00, 8'h01, 8'h00, 8'hb2, 8'hff, 8'h05, 8'h00, 8'h00});
    xf('{CODE_READ, 8'hff, 8'h05, 8'h02}, '{ERR_BYTE});
    xf('{CODE_READ, 8'h00, 8'h00}, '{ERR_BYTE});
    xf('{CODE_WRITE, 8'hff, 8'h05, 8'h11, 8'h22}, '{ERR_BYTE});
    xf('{CODE_READ, 8'hff, 8'h05, 8'h01}, '{8'hff, 8'h05, 8'h00});
    $display("t_rng end");
  endtask
  task automatic t_map();
    logic [31:0]  a[7] = '{32'h0, 32'h1fffc, 32'h10007ffc, 32'h2003ffff, 32'h20050000, 32'h40000000, 32'h30000000};
    pmae_region_e r[7] = '{REG_PRAM, REG_PRAM, REG_DRAM, REG_BNV, REG_UNV, REG_HWR, REG_NONE};
    foreach (a[i]) begin
      map_addr <= a[i];
      map_wr <= i != 4;
      repeat (2) @(posedge sys_clk);
      chk("region", map_region, r[i]);
      chk("trap", map_trap, i inside {1, 2});
      chk("wr_ok", map_wr_ok, !(i inside {3, 4, 6}));
    end
    $display("t_map end");
  endtask
  // Trap word: one set bit is corrected, two are only counted
  task automatic t_trap();
    chk("errs", err_count, 32'h0);
    xf('{CODE_WRITE, 8'hfc, 8'h05, 8'h01, 8'h03}, '{8'hfc, 8'h05, 8'h01, 8'h03});
    xf('{CODE_READ, 8'hfc, 8'h05, 8'h02}, '{8'hfc, 8'h05, 8'h00, 8'h03});
    chk("errs", {err_count[31:16] != 16'h0, err_count[15:0] != 16'h0}, 2'h3);
    $display("t_trap end");
  endtask
  task automatic t_warm();
    pwr_on_rst <= 1'h0;
    rst_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    xf('{CODE_READ, 8'h10, 8'h00, 8'h03}, '{8'h10, 8'h00, 8'ha1, 8'hb2, 8'hc3});
    $display("t_warm end");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Power-on reset, then each scenario in turn
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_rw();
    t_full();
    t_rng();
    t_map();
    t_trap();
    t_warm();
    complete_run();
  end
endmodule
bind pmae_core pmae_checker #(.NV_ON_CYC(NV_ON_CYC)) pmae_checker_i (.sys_clk, .rst_n, .rsp_valid, .rsp_data,
  .rsp_ready, .map_addr, .map_wr, .map_region, .map_trap, .map_wr_ok, .nv_pwr_on, .nv_rd_req, .pram_we,
  .pram_addr, .pram_wdata);
